// ===== logic/lcd_panel_output_control.sv
`timescale 1ns/1ns
module lcd_panel_output_control (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_pixel_clk,
  input  wire logic        i_power_saving,
  input  wire logic        i_hsync_raw,
  input  wire logic        i_vsync_raw,
  input  wire logic        i_data_active,
  input  wire logic [23:0] i_main_pixel,
  input  wire logic        i_overlay1_hit,
  input  wire logic [23:0] i_overlay1_pixel,
  input  wire logic        i_overlay2_hit,
  input  wire logic [23:0] i_overlay2_pixel,
  input  wire logic        i_graphic_cursor_request,
  input  wire logic        i_text_cursor_request,
  output logic             o_pixel_clk,
  output logic             o_hsync,
  output logic             o_vsync,
  output logic             o_panel_data_valid,
  output logic [23:0]      o_panel_pixel_bus,
  output logic [23:0]      o_panel_pixel_bus_oe,
  output logic             o_pixel_launch,
  output logic             o_overlay1_show,
  output logic             o_overlay2_show,
  output logic             o_graphic_cursor_enable,
  output logic             o_text_cursor_enable,
  output logic             o_overlay_param_select,
  output logic             o_scan_bottom_up,
  output logic [4:0]       o_main_bits_per_pixel,
  output logic [4:0]       o_overlay1_bits_per_pixel,
  output logic [4:0]       o_overlay2_bits_per_pixel
);

  function automatic logic [4:0] depth_bpp(input logic [1:0] code);
    // upper bit set means 24 bpp whatever the lower bit
    if (code[1]) begin
      depth_bpp = panel_output_pkg::BPP_24;
    end else if (code == panel_output_pkg::DEPTH_16) begin
      depth_bpp = panel_output_pkg::BPP_16;
    end else begin
      depth_bpp = panel_output_pkg::BPP_8;
    end
  endfunction

  function automatic logic [23:0] reorder(input logic [23:0] pix,
                                          input logic [2:0]  seq);
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic [9:0] y;
    r = pix[23:16];
    g = pix[15:8];
    b = pix[7:0];
    y = 10'({2'h0, r} + {1'h0, g, 1'h0} + {2'h0, b});
    case (panel_output_pkg::out_sequence_type'(seq))
      panel_output_pkg::SEQ_RGB:  reorder = {r, g, b};
      panel_output_pkg::SEQ_RBG:  reorder = {r, b, g};
      panel_output_pkg::SEQ_GRB:  reorder = {g, r, b};
      panel_output_pkg::SEQ_GBR:  reorder = {g, b, r};
      panel_output_pkg::SEQ_BRG:  reorder = {b, r, g};
      panel_output_pkg::SEQ_BGR:  reorder = {b, g, r};
      panel_output_pkg::SEQ_GRAY: reorder = {y[9:2], y[9:2], y[9:2]};
      default:                    reorder = 24'h000000;
    endcase
  endfunction

  logic [7:0]  window_and_panel_mode_control;
  logic [7:0]  overlay_colour_depth;
  logic [7:0]  display_configuration;
  logic [7:0]  panel_signal_polarity_idle;
  logic [15:0] overlay1_width;
  logic [15:0] overlay2_width;
  logic [7:0]  next_window_ctrl;
  logic [7:0]  next_overlay_depth;
  logic [7:0]  next_display_cfg;
  logic [7:0]  next_polarity;
  logic [15:0] next_overlay1_width;
  logic [15:0] next_overlay2_width;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        access;
  logic        commit;
  logic        hit;
  logic [31:0] read_value;

  logic        clk_sync;
  logic        clk_prev;
  localparam int BAR_W = panel_output_pkg::BAR_COUNT_W;
  logic [BAR_W-1:0] bar_count;
  logic [BAR_W-1:0] next_bar_count;
  logic        next_clk_prev;
  logic        next_pixel_clk;
  logic        next_hsync;
  logic        next_vsync;
  logic        next_data_valid;
  logic [23:0] next_pixel_bus;
  logic [23:0] next_pixel_oe;
  logic        next_launch;
  logic        panel_off;
  logic        clk_rise;
  logic        clk_fall;
  logic        launch;
  logic        bottom_up;
  logic        ov1_on;
  logic        ov2_on;
  logic [2:0]  seq;
  logic [23:0] bar_pixel;
  logic [23:0] source_pixel;

  level_synchronizer #(.WIDTH(1)) u_pixel_clk_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_pixel_clk),
    .o_sync    (clk_sync)
  );

  // register bus: one wait state so read data leaves a flip-flop
  always_comb begin
    access = i_psel & i_penable;
    commit = access & o_pready;
    hit = 1'b1;
    read_value = 32'h00000000;
    if (i_paddr == panel_output_pkg::ADDR_WINDOW_CTRL) begin
      read_value[7:0] = window_and_panel_mode_control;
    end else if (i_paddr == panel_output_pkg::ADDR_OVERLAY_DEPTH) begin
      read_value[7:0] = overlay_colour_depth;
    end else if (i_paddr == panel_output_pkg::ADDR_DISPLAY_CFG) begin
      read_value[7:0] = display_configuration;
    end else if (i_paddr == panel_output_pkg::ADDR_POLARITY_IDLE) begin
      read_value[7:0] = panel_signal_polarity_idle;
    end else if (i_paddr == panel_output_pkg::ADDR_OVERLAY_WIDTH) begin
      read_value[15:0] = o_overlay_param_select ? overlay2_width
                                                : overlay1_width;
    end else if (i_paddr == panel_output_pkg::ADDR_PANEL_STATUS) begin
      read_value[3:0] = {o_pixel_clk, o_scan_bottom_up,
                         o_panel_data_valid, panel_off};
    end else begin
      hit = 1'b0;
    end
    next_pready  = access & ~o_pready;
    next_pslverr = access & ~o_pready & ~hit;
    next_prdata  = (access & ~o_pready & ~i_pwrite) ? read_value : o_prdata;
    next_window_ctrl    = window_and_panel_mode_control;
    next_overlay_depth  = overlay_colour_depth;
    next_display_cfg    = display_configuration;
    next_polarity       = panel_signal_polarity_idle;
    next_overlay1_width = overlay1_width;
    next_overlay2_width = overlay2_width;
    if (commit && i_pwrite) begin
      if (i_paddr == panel_output_pkg::ADDR_WINDOW_CTRL) begin
        next_window_ctrl = i_pwdata[7:0] & panel_output_pkg::WINDOW_CTRL_MASK;
      end else if (i_paddr == panel_output_pkg::ADDR_OVERLAY_DEPTH) begin
        next_overlay_depth = i_pwdata[7:0]
                             & panel_output_pkg::OVERLAY_DEPTH_MASK;
      end else if (i_paddr == panel_output_pkg::ADDR_DISPLAY_CFG) begin
        next_display_cfg = i_pwdata[7:0];
      end else if (i_paddr == panel_output_pkg::ADDR_POLARITY_IDLE) begin
        next_polarity = i_pwdata[7:0];
      end else if (i_paddr == panel_output_pkg::ADDR_OVERLAY_WIDTH) begin
        if (o_overlay_param_select) begin
          next_overlay2_width = i_pwdata[15:0];
        end else begin
          next_overlay1_width = i_pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      window_and_panel_mode_control <= panel_output_pkg::WINDOW_CTRL_RST;
      overlay_colour_depth          <= panel_output_pkg::OVERLAY_DEPTH_RST;
      display_configuration         <= panel_output_pkg::DISPLAY_CFG_RST;
      panel_signal_polarity_idle    <= panel_output_pkg::POLARITY_RST;
      overlay1_width                <= panel_output_pkg::OVERLAY_WIDTH_RST;
      overlay2_width                <= panel_output_pkg::OVERLAY_WIDTH_RST;
      o_prdata                      <= 32'h00000000;
      o_pready                      <= 1'b0;
      o_pslverr                     <= 1'b0;
    end else begin
      window_and_panel_mode_control <= next_window_ctrl;
      overlay_colour_depth          <= next_overlay_depth;
      display_configuration         <= next_display_cfg;
      panel_signal_polarity_idle    <= next_polarity;
      overlay1_width                <= next_overlay1_width;
      overlay2_width                <= next_overlay2_width;
      o_prdata                      <= next_prdata;
      o_pready                      <= next_pready;
      o_pslverr                     <= next_pslverr;
    end
  end

  // panel output stage
  always_comb begin
    panel_off = ~display_configuration[panel_output_pkg::DISP_ON_BIT]
                | i_power_saving;
    clk_rise = clk_sync & ~clk_prev;
    clk_fall = ~clk_sync & clk_prev;
    launch = display_configuration[panel_output_pkg::PCLK_INV_BIT]
             ? clk_rise : clk_fall;
    bottom_up = display_configuration[panel_output_pkg::VERTICAL_SCAN_DIRECTION_BIT];
    ov1_on = window_and_panel_mode_control[panel_output_pkg::OV1_EN_BIT]
             & ~bottom_up;
    ov2_on = window_and_panel_mode_control[panel_output_pkg::OV2_EN_BIT]
             & ~bottom_up;
    seq = display_configuration[panel_output_pkg::SEQ_LSB +: 3];
    bar_pixel = {{8{bar_count[BAR_W-1]}}, {8{bar_count[BAR_W-2]}},
                 {8{bar_count[BAR_W-3]}}};
    if (display_configuration[panel_output_pkg::COLOR_BAR_BIT]) begin
      source_pixel = bar_pixel;
    end else if (ov1_on && i_overlay1_hit) begin
      source_pixel = i_overlay1_pixel;
    end else if (ov2_on && i_overlay2_hit) begin
      source_pixel = i_overlay2_pixel;
    end else begin
      source_pixel = i_main_pixel;
    end
    next_clk_prev = clk_sync;
    next_launch = launch;
    next_bar_count = bar_count;
    if (!i_data_active) begin
      next_bar_count = '0;
    end else if (launch) begin
      next_bar_count = BAR_W'(bar_count + 1'b1);
    end
    next_pixel_clk = panel_off
        ? panel_signal_polarity_idle[panel_output_pkg::CLK_IDLE_BIT]
        : clk_sync;
    if (panel_off
        || window_and_panel_mode_control[panel_output_pkg::PANEL_MODE_BIT])
    begin
      next_hsync = panel_signal_polarity_idle[panel_output_pkg::HS_IDLE_BIT];
      next_vsync = panel_signal_polarity_idle[panel_output_pkg::VS_IDLE_BIT];
    end else begin
      next_hsync = i_hsync_raw
          ^ ~panel_signal_polarity_idle[panel_output_pkg::HS_POL_BIT];
      next_vsync = i_vsync_raw
          ^ ~panel_signal_polarity_idle[panel_output_pkg::VS_POL_BIT];
    end
    next_data_valid = panel_off
        ? panel_signal_polarity_idle[panel_output_pkg::DE_IDLE_BIT]
        : i_data_active
          ^ panel_signal_polarity_idle[panel_output_pkg::DE_POL_BIT];
    if (panel_off || !i_data_active
        || seq == 3'(panel_output_pkg::SEQ_IDLE)) begin
      next_pixel_bus =
          {24{panel_signal_polarity_idle[panel_output_pkg::PIX_IDLE_BIT]}};
    end else if (launch) begin
      next_pixel_bus = reorder(source_pixel, seq);
    end else begin
      next_pixel_bus = o_panel_pixel_bus;
    end
    next_pixel_oe = window_and_panel_mode_control
                    [panel_output_pkg::MAIN_DEPTH_LSB + 1]
                    ? 24'hFFFFFF : ~panel_output_pkg::SHARED_PIN_MASK;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      clk_prev                  <= 1'b0;
      bar_count                 <= '0;
      o_pixel_clk               <= 1'b0;
      o_hsync                   <= 1'b1;
      o_vsync                   <= 1'b1;
      o_panel_data_valid        <= 1'b0;
      o_panel_pixel_bus         <= 24'h000000;
      o_panel_pixel_bus_oe      <= 24'h000000;
      o_pixel_launch            <= 1'b0;
      o_overlay1_show           <= 1'b0;
      o_overlay2_show           <= 1'b0;
      o_graphic_cursor_enable   <= 1'b0;
      o_text_cursor_enable      <= 1'b0;
      o_overlay_param_select    <= 1'b0;
      o_scan_bottom_up          <= 1'b0;
      o_main_bits_per_pixel     <= panel_output_pkg::BPP_16;
      o_overlay1_bits_per_pixel <= panel_output_pkg::BPP_16;
      o_overlay2_bits_per_pixel <= panel_output_pkg::BPP_16;
    end else begin
      clk_prev                  <= next_clk_prev;
      bar_count                 <= next_bar_count;
      o_pixel_clk               <= next_pixel_clk;
      o_hsync                   <= next_hsync;
      o_vsync                   <= next_vsync;
      o_panel_data_valid        <= next_data_valid;
      o_panel_pixel_bus         <= next_pixel_bus;
      o_panel_pixel_bus_oe      <= next_pixel_oe;
      o_pixel_launch            <= next_launch;
      o_overlay1_show           <= ov1_on;
      o_overlay2_show           <= ov2_on;
      o_graphic_cursor_enable   <= i_graphic_cursor_request & ~bottom_up;
      o_text_cursor_enable      <= i_text_cursor_request & ~bottom_up;
      o_overlay_param_select    <=
          window_and_panel_mode_control[panel_output_pkg::OV_SEL_BIT];
      o_scan_bottom_up          <= bottom_up;
      o_main_bits_per_pixel     <= depth_bpp(window_and_panel_mode_control
          [panel_output_pkg::MAIN_DEPTH_LSB +: 2]);
      o_overlay1_bits_per_pixel <= depth_bpp(overlay_colour_depth
          [panel_output_pkg::OV1_DEPTH_LSB +: 2]);
      o_overlay2_bits_per_pixel <= depth_bpp(overlay_colour_depth
          [panel_output_pkg::OV2_DEPTH_LSB +: 2]);
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_overlay_gate: assert property (
    (window_and_panel_mode_control[7] && !bottom_up) |=> o_overlay1_show)
    else $error("overlay one not shown while enabled");
  a_overlay_top: assert property (
    (launch && !panel_off && i_data_active && ov1_on && ov2_on
     && i_overlay1_hit && i_overlay2_hit && seq == 3'h0
     && !display_configuration[5])
    |=> o_panel_pixel_bus == $past(i_overlay1_pixel))
    else $error("second overlay shown above first");
  a_select_steer: assert property (
    (commit && i_pwrite && i_paddr == panel_output_pkg::ADDR_OVERLAY_WIDTH
     && !o_overlay_param_select)
    |=> overlay1_width == $past(i_pwdata[15:0])
        && $stable(overlay2_width))
    else $error("overlay parameter write went to wrong copy");
  a_main_depth: assert property (
    window_and_panel_mode_control[3] |=> o_main_bits_per_pixel == 5'h18)
    else $error("main depth not 24 bpp");
  a_overlay_depth: assert property (
    overlay_colour_depth[3:2] == 2'h0 |=> o_overlay1_bits_per_pixel == 5'h08)
    else $error("overlay one depth not 8 bpp");
  a_de_mode_sync: assert property (
    window_and_panel_mode_control[0] ##1 window_and_panel_mode_control[0]
    |-> o_hsync == $past(panel_signal_polarity_idle[1])
        && o_vsync == $past(panel_signal_polarity_idle[0]))
    else $error("sync toggled in data valid mode");
  a_launch_edge: assert property (
    (!display_configuration[7] && clk_fall) |=> o_pixel_launch)
    else $error("no launch after falling pixel clock");
  a_scan_cursor: assert property (
    bottom_up |=> !o_graphic_cursor_enable && !o_text_cursor_enable
                  && !o_overlay1_show && !o_overlay2_show)
    else $error("cursor or overlay active in bottom up scan");
  a_clock_idle: assert property (
    panel_off |=> o_pixel_clk == $past(panel_signal_polarity_idle[3]))
    else $error("pixel clock not parked while off");
  a_pixel_idle: assert property (
    (panel_off || !i_data_active)
    |=> o_panel_pixel_bus == {24{$past(panel_signal_polarity_idle[2])}})
    else $error("pixel bus not idle outside display");

  c_overlay_both: cover property (launch && ov1_on && ov2_on);
  c_color_bar: cover property (launch && display_configuration[5]
                               && i_data_active && !panel_off);
  c_read_done: cover property (commit && !i_pwrite);

endmodule // lcd_panel_output_control

// ===== logic/panel_output_pkg.sv
package panel_output_pkg;

  // register indices; byte address is the index times four
  localparam logic [7:0]  IDX_WINDOW_CTRL   = 8'h10;
  localparam logic [7:0]  IDX_OVERLAY_DEPTH = 8'h11;
  localparam logic [7:0]  IDX_DISPLAY_CFG   = 8'h12;
  localparam logic [7:0]  IDX_POLARITY_IDLE = 8'h13;
  localparam logic [7:0]  IDX_OVERLAY_WIDTH = 8'h30;
  localparam logic [7:0]  IDX_PANEL_STATUS  = 8'h31;
  localparam logic [11:0] ADDR_WINDOW_CTRL   = {2'h0, IDX_WINDOW_CTRL, 2'h0};
  localparam logic [11:0] ADDR_OVERLAY_DEPTH = {2'h0, IDX_OVERLAY_DEPTH, 2'h0};
  localparam logic [11:0] ADDR_DISPLAY_CFG   = {2'h0, IDX_DISPLAY_CFG, 2'h0};
  localparam logic [11:0] ADDR_POLARITY_IDLE = {2'h0, IDX_POLARITY_IDLE, 2'h0};
  localparam logic [11:0] ADDR_OVERLAY_WIDTH = {2'h0, IDX_OVERLAY_WIDTH, 2'h0};
  localparam logic [11:0] ADDR_PANEL_STATUS  = {2'h0, IDX_PANEL_STATUS, 2'h0};

  // window_and_panel_mode_control fields
  localparam int OV1_EN_BIT     = 7;
  localparam int OV2_EN_BIT     = 6;
  localparam int OV_SEL_BIT     = 4;
  localparam int MAIN_DEPTH_LSB = 2;
  localparam int PANEL_MODE_BIT = 0;
  // overlay_colour_depth fields
  localparam int OV1_DEPTH_LSB  = 2;
  localparam int OV2_DEPTH_LSB  = 0;
  // display_configuration fields
  localparam int PCLK_INV_BIT   = 7;
  localparam int DISP_ON_BIT    = 6;
  localparam int COLOR_BAR_BIT  = 5;
  localparam int VERTICAL_SCAN_DIRECTION_BIT       = 3;
  localparam int SEQ_LSB        = 0;
  // panel_signal_polarity_idle fields
  localparam int HS_POL_BIT     = 7;
  localparam int VS_POL_BIT     = 6;
  localparam int DE_POL_BIT     = 5;
  localparam int DE_IDLE_BIT    = 4;
  localparam int CLK_IDLE_BIT   = 3;
  localparam int PIX_IDLE_BIT   = 2;
  localparam int HS_IDLE_BIT    = 1;
  localparam int VS_IDLE_BIT    = 0;

  localparam logic [7:0]  WINDOW_CTRL_RST   = 8'h04;
  localparam logic [7:0]  OVERLAY_DEPTH_RST = 8'h05;
  localparam logic [7:0]  DISPLAY_CFG_RST   = 8'h00;
  localparam logic [7:0]  POLARITY_RST      = 8'h03;
  localparam logic [15:0] OVERLAY_WIDTH_RST = 16'h0000;
  localparam logic [7:0]  WINDOW_CTRL_MASK  = 8'hDF;
  localparam logic [7:0]  OVERLAY_DEPTH_MASK = 8'h0F;

  localparam logic [1:0]  DEPTH_8  = 2'h0;
  localparam logic [1:0]  DEPTH_16 = 2'h1;
  localparam logic [4:0]  BPP_8    = 5'h08;
  localparam logic [4:0]  BPP_16   = 5'h10;
  localparam logic [4:0]  BPP_24   = 5'h18;

  // pins that double as general purpose or keypad scan below 24 bpp
  localparam logic [23:0] SHARED_PIN_MASK = 24'h070307;
  localparam int          BAR_COUNT_W     = 10;

  typedef enum logic [2:0] {
    SEQ_RGB, SEQ_RBG, SEQ_GRB, SEQ_GBR, SEQ_BRG, SEQ_BGR, SEQ_GRAY, SEQ_IDLE
  } out_sequence_type;

endpackage

// ===== logic/level_synchronizer.sv
`timescale 1ns/1ns
module level_synchronizer #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // level_synchronizer

// ===== verification/panel_model.sv
`timescale 1ns/1ns
module panel_model (
  input  wire logic        i_pclk,
  input  wire logic        i_fall_edge,
  input  wire logic        i_valid,
  input  wire logic [23:0] i_pixel,
  output logic      [23:0] o_sample
);
  // fetch on rising pclk, falling when inverted
  always @(posedge i_pclk or negedge i_pclk) begin
    if (i_valid && (i_pclk != i_fall_edge)) begin
      o_sample <= i_pixel;
    end
  end
endmodule // panel_model

// ===== verification/lcd_panel_output_control_tb.sv
`timescale 1ns/1ns
module lcd_panel_output_control_tb;
  logic i_ref_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_pixel_clk;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, i_power_saving, i_hsync_raw, i_vsync_raw;
  logic i_data_active, i_overlay1_hit, i_overlay2_hit, o_pixel_clk;
  logic [23:0] i_main_pixel, i_overlay1_pixel, i_overlay2_pixel, sample;
  logic i_graphic_cursor_request, i_text_cursor_request, o_hsync, o_vsync;
  logic o_panel_data_valid, o_pixel_launch, o_overlay1_show;
  logic [23:0] o_panel_pixel_bus, o_panel_pixel_bus_oe;
  logic o_overlay2_show, o_graphic_cursor_enable, o_text_cursor_enable;
  logic o_overlay_param_select, o_scan_bottom_up;
  logic [4:0] o_main_bits_per_pixel, o_overlay1_bits_per_pixel;
  logic [4:0] o_overlay2_bits_per_pixel;
  logic [31:0] rdata;
  logic err, fall_edge;
  int num_errors = 0;
  int checked = 0;
  lcd_panel_output_control dut_u (.*);
  panel_model panel_u (
    .i_pclk   (o_pixel_clk),
    .i_fall_edge (fall_edge),
    .i_valid  (o_panel_data_valid),
    .i_pixel  (o_panel_pixel_bus),
    .o_sample (sample)
  );
  initial i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;
  initial i_pixel_clk = 1'b0;
  always #80 i_pixel_clk = ~i_pixel_clk;
  task automatic print_verdict();
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  // hold the request until pready is sampled high, take the answer there
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge i_ref_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    rdata = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'b00;
    // registered outputs follow the written register one edge later
    repeat (2) @(negedge i_ref_clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic launch(input int n);
    repeat (n) begin
      do @(negedge i_ref_clk); while (o_pixel_launch !== 1'b1);
    end
  endtask
  function automatic logic [23:0] exp_seq(input logic [2:0] s,
                                          input logic [23:0] p);
    logic [9:0] y;
    y = {2'h0, p[23:16]} + {1'h0, p[15:8], 1'h0} + {2'h0, p[7:0]};
    case (s)
      3'h0: return p;
      3'h1: return {p[23:16], p[7:0], p[15:8]};
      3'h2: return {p[15:8], p[23:16], p[7:0]};
      3'h3: return {p[15:8], p[7:0], p[23:16]};
      3'h4: return {p[7:0], p[23:16], p[15:8]};
      3'h5: return {p[7:0], p[15:8], p[23:16]};
      default: return {3{y[9:2]}};
    endcase
  endfunction
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {i_reset_n, i_psel, i_penable, i_pwrite, i_power_saving, fall_edge} = 6'h00;
    {i_paddr, i_pwdata} = 44'h0;
    {i_hsync_raw, i_vsync_raw, i_data_active} = 3'h0;
    {i_overlay1_hit, i_overlay2_hit} = 2'h0;
    {i_graphic_cursor_request, i_text_cursor_request} = 2'h3;
    i_main_pixel = 24'h112233;
    i_overlay1_pixel = 24'h445566;
    i_overlay2_pixel = 24'h778899;
    repeat (4) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rchk(panel_output_pkg::ADDR_WINDOW_CTRL, 32'h04);
    rchk(panel_output_pkg::ADDR_OVERLAY_DEPTH, 32'h05);
    rchk(panel_output_pkg::ADDR_DISPLAY_CFG, 32'h00);
    rchk(panel_output_pkg::ADDR_POLARITY_IDLE, 32'h03);
    chk({o_hsync, o_vsync, o_panel_data_valid}, 3'h6);
    chk(o_panel_pixel_bus_oe, 24'hF8FCF8);
    rchk(12'h000, 32'h0);
    chk(err, 1'b1);
    xfer(1'b1, panel_output_pkg::ADDR_OVERLAY_WIDTH, 32'hABCD);
    rchk(panel_output_pkg::ADDR_OVERLAY_WIDTH, 32'hABCD);
    xfer(1'b1, panel_output_pkg::ADDR_WINDOW_CTRL, 32'hF8);
    rchk(panel_output_pkg::ADDR_WINDOW_CTRL, 32'hD8);
    rchk(panel_output_pkg::ADDR_OVERLAY_WIDTH, 32'h0);
    chk(o_overlay_param_select, 1'b1);
    chk(o_main_bits_per_pixel, 5'h18);
    chk(o_panel_pixel_bus_oe, 24'hFFFFFF);
    xfer(1'b1, panel_output_pkg::ADDR_OVERLAY_DEPTH, 32'h02);
    chk({o_overlay1_bits_per_pixel, o_overlay2_bits_per_pixel},
        10'h118);
    @(posedge i_ref_clk);
    {i_overlay1_hit, i_overlay2_hit, i_data_active, i_hsync_raw} <= 4'hF;
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h40);
    launch(2);
    chk(o_panel_pixel_bus, 24'h445566);
    chk({o_overlay1_show, o_overlay2_show}, 2'h3);
    chk(o_hsync, 1'b0);
    chk(o_pixel_clk, 1'b0);
    chk(sample, 24'h445566);
    @(posedge i_ref_clk);
    {i_overlay1_hit, i_overlay2_hit} <= 2'h0;
    for (int s = 0; s < 7; s++) begin
      xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h40 | s);
      launch(2);
      chk(o_panel_pixel_bus, exp_seq(s[2:0], 24'h112233));
    end
    fall_edge <= 1'b1;
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'hC0);
    launch(2);
    chk(o_pixel_clk, 1'b1);
    chk(sample, 24'h112233);
    fall_edge <= 1'b0;
    // software pairs the idle code with the pixel idle level
    xfer(1'b1, panel_output_pkg::ADDR_POLARITY_IDLE, 32'h07);
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h47);
    repeat (3) @(negedge i_ref_clk);
    chk(o_panel_pixel_bus, 24'hFFFFFF);
    xfer(1'b1, panel_output_pkg::ADDR_WINDOW_CTRL, 32'hD9);
    repeat (3) @(negedge i_ref_clk);
    chk(o_hsync, 1'b1);
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h60);
    // a gap in active display restarts the bar counter
    @(posedge i_ref_clk);
    i_data_active <= 1'b0;
    @(posedge i_ref_clk);
    i_data_active <= 1'b1;
    launch(2);
    chk(o_panel_pixel_bus, 24'h000000);
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h48);
    chk({o_overlay1_show, o_overlay2_show, o_graphic_cursor_enable,
         o_text_cursor_enable, o_scan_bottom_up}, 5'h01);
    xfer(1'b1, panel_output_pkg::ADDR_POLARITY_IDLE, 32'h1C);
    @(posedge i_ref_clk);
    i_power_saving <= 1'b1;
    repeat (3) @(negedge i_ref_clk);
    chk({o_pixel_clk, o_panel_data_valid}, 2'h3);
    @(posedge i_ref_clk);
    i_power_saving <= 1'b0;
    xfer(1'b1, panel_output_pkg::ADDR_DISPLAY_CFG, 32'h00);
    repeat (6) @(negedge i_ref_clk);
    chk({o_pixel_clk, o_panel_data_valid}, 2'h3);
    chk(o_panel_pixel_bus, 24'hFFFFFF);
    chk({o_hsync, o_vsync}, 2'h0);
    rchk(panel_output_pkg::ADDR_PANEL_STATUS, 32'h0B);
    print_verdict();
  end
endmodule // lcd_panel_output_control_tb
